//--- rtl/reset_ctl_cfg.svh
`ifndef RESET_CTL_CFG_SVH
`define RESET_CTL_CFG_SVH

// Processor clock period in nanoseconds (20 MHz).
`define CLK_PERIOD_NS       50
// Least power-up hold of the reset pin, in processor clocks.
`define CPU_HOLD_CYCLES     16
// Least power-up hold of the reset pin for memory, in nanoseconds.
`define DRAM_HOLD_NS        200000
`define DRAM_HOLD_CYCLES    ((`DRAM_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Width of the hold counter; it saturates at the memory hold count.
`define HOLD_CNT_W          12
// Length of the watchdog reset pulse in processor clocks.
`define WDOG_PULSE_CYCLES   4
`define WDOG_CNT_W          3
// Refresh interval code left after power-on: one refresh every 128 clocks.
`define REFRESH_POR_VALUE   2'h0

`endif

//--- rtl/reset_ctl_pkg.sv
package reset_ctl_pkg;

   typedef enum logic [2:0] {
      ST_RUN       = 3'h1,
      ST_GEN_RESET = 3'h2,
      ST_WATCHDOG  = 3'h4
   } reset_state_t;

   // Reset lines handed to the rest of the processor.
   typedef struct packed {
      logic general;       // Whole chip and system bus.
      logic integer_unit;  // Integer unit only.
      logic boot_mode;     // Boot mode bit of the control register.
      logic watchdog;      // Watchdog reset in progress.
   } reset_out_t;

   // Power-up hold checks seen when the first general reset ended.
   typedef struct packed {
      logic cpu_hold_short;
      logic dram_hold_short;
   } hold_status_t;

   typedef struct packed {
      reset_state_t  state;
      logic          pin_sync1;
      logic          pin_sync2;
      logic [11:0]   hold_cnt;
      logic [2:0]    wdog_cnt;
      logic          por_pending;
      logic [1:0]    refresh_interval_field;
      hold_status_t  hold;
   } ctl_state_t;

endpackage

//--- rtl/processor_reset_control.sv
`include "reset_ctl_cfg.svh"

// Operation
// RULE1 - Only general reset and watchdog reset exist.
// RULE2 - Trap with traps disabled raises watchdog reset.
// RULE3 - Watchdog resets integer unit and boot bit only.
// RULE4 - Reset pin asserted starts a general reset.
// RULE5 - Board holds reset 16 clocks after power-up.
// RULE6 - Board holds reset 200 us after power-up.
// RULE7 - Power-on reset end clears refresh interval field.
// RULE8 - Test port reset acts asynchronously.
// RULE9 - Pin release synchronised before internal release.
module processor_reset_control (
   input  wire logic                      sys_clk,         // Processor clock.
   input  wire logic                      sys_rst,         // Power-on, high.
   input  wire logic                      reset_pin_n,     // Board reset pin.
   input  wire logic                      trap_taken,      // Trap this cycle.
   input  wire logic                      trap_enable_bit, // State reg trap en.
   input  wire logic                      refresh_wr_en,   // Field write strobe.
   input  wire logic [1:0]                refresh_wr_data, // Field write value.
   input  wire logic                      test_port_reset_n, // Test port reset.
   output reset_ctl_pkg::reset_out_t      resets,          // Reset lines.
   output logic [1:0]                     refresh_interval_field, // Field.
   output reset_ctl_pkg::hold_status_t    hold_status,     // Power-up checks.
   output logic                           test_logic_reset // Test logic reset.
);

   localparam logic [11:0] CPU_HOLD  = 12'(`CPU_HOLD_CYCLES);
   localparam logic [11:0] DRAM_HOLD = 12'(`DRAM_HOLD_CYCLES);
   localparam logic [2:0]  WDOG_LAST = 3'(`WDOG_PULSE_CYCLES - 1);

   reset_ctl_pkg::ctl_state_t cur_reg;
   reset_ctl_pkg::ctl_state_t cur_next;

   logic wdog_cause;
   logic pin_req;

   // The pin is seen only through the second synchroniser stage, so every
   // unit leaves reset on one and the same clock edge.
   assign pin_req    = cur_reg.pin_sync2;                             // [RULE9]
   assign wdog_cause = trap_taken && !trap_enable_bit;                // [RULE2]

   always_comb begin
      cur_next = cur_reg;
      cur_next.pin_sync1 = !reset_pin_n;                              // [RULE4]
      cur_next.pin_sync2 = cur_reg.pin_sync1;                         // [RULE9]
      if (refresh_wr_en) begin
         cur_next.refresh_interval_field = refresh_wr_data;
      end
      unique case (cur_reg.state)
         reset_ctl_pkg::ST_RUN: begin
            if (pin_req) begin
               cur_next.state    = reset_ctl_pkg::ST_GEN_RESET;       // [RULE4]
               cur_next.hold_cnt = 12'h000;
            end else if (wdog_cause) begin
               cur_next.state    = reset_ctl_pkg::ST_WATCHDOG;        // [RULE2]
               cur_next.wdog_cnt = WDOG_LAST;
            end
         end
         reset_ctl_pkg::ST_WATCHDOG: begin
            // A general reset overrides a watchdog reset in progress.
            if (pin_req) begin
               cur_next.state    = reset_ctl_pkg::ST_GEN_RESET;       // [RULE1]
               cur_next.hold_cnt = 12'h000;
            end else if (cur_reg.wdog_cnt == 3'h0) begin
               cur_next.state = reset_ctl_pkg::ST_RUN;
            end else begin
               cur_next.wdog_cnt = cur_reg.wdog_cnt - 3'h1;
            end
         end
         reset_ctl_pkg::ST_GEN_RESET: begin
            // Software cannot move the field while the chip is held in reset.
            cur_next.refresh_interval_field = cur_reg.refresh_interval_field;
            if (cur_reg.hold_cnt != DRAM_HOLD) begin
               cur_next.hold_cnt = cur_reg.hold_cnt + 12'h001;
            end
            if (!pin_req) begin
               cur_next.state = reset_ctl_pkg::ST_RUN;                // [RULE9]
               if (cur_reg.por_pending) begin
                  cur_next.por_pending = 1'b0;
                  cur_next.refresh_interval_field = `REFRESH_POR_VALUE; // [RULE7]
                  // The board's hold time is only reported; the chip
                  // cannot stretch a reset it does not own.
                  cur_next.hold.cpu_hold_short  =
                     (cur_reg.hold_cnt < CPU_HOLD);                   // [RULE5]
                  cur_next.hold.dram_hold_short =
                     (cur_reg.hold_cnt < DRAM_HOLD);                  // [RULE6]
               end
            end
         end
         default: begin
            cur_next.state    = reset_ctl_pkg::ST_GEN_RESET;
            cur_next.hold_cnt = 12'h000;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cur_reg.state                  <= reset_ctl_pkg::ST_GEN_RESET;
         cur_reg.pin_sync1              <= 1'b1;
         cur_reg.pin_sync2              <= 1'b1;
         cur_reg.hold_cnt               <= 12'h000;
         cur_reg.wdog_cnt               <= 3'h0;
         cur_reg.por_pending            <= 1'b1;
         cur_reg.refresh_interval_field <= `REFRESH_POR_VALUE;
         cur_reg.hold                   <= 2'h0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // Watchdog reset touches only the integer unit and the boot mode bit;
   // the general line, and with it every other unit, stays quiet.
   assign resets.general      = (cur_reg.state == reset_ctl_pkg::ST_GEN_RESET);
   assign resets.watchdog     = (cur_reg.state == reset_ctl_pkg::ST_WATCHDOG);
   assign resets.integer_unit = resets.general || resets.watchdog;    // [RULE3]
   assign resets.boot_mode    = resets.general || resets.watchdog;    // [RULE3]
   assign refresh_interval_field = cur_reg.refresh_interval_field;
   assign hold_status            = cur_reg.hold;

   // No flop sits in this path, so the test logic is reset with no clock.
   assign test_logic_reset = !test_port_reset_n;                      // [RULE8]

   a_two_kinds: assert property ( // [RULE1]
      @(posedge sys_clk) disable iff (sys_rst)
      !(resets.general && resets.watchdog))
      else $error("general and watchdog reset active together");

   a_wdog_entry: assert property ( // [RULE2]
      @(posedge sys_clk) disable iff (sys_rst)
      (cur_reg.state == reset_ctl_pkg::ST_RUN) && !pin_req &&
      trap_taken && !trap_enable_bit |=> resets.watchdog)
      else $error("trap with traps disabled gave no watchdog reset");

   a_wdog_length: assert property ( // [RULE2]
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(resets.watchdog) |->
         (resets.watchdog || resets.general)[*4] ##1 !resets.watchdog)
      else $error("watchdog reset pulse has wrong length");

   a_wdog_scope: assert property ( // [RULE3]
      @(posedge sys_clk) disable iff (sys_rst)
      resets.watchdog |-> resets.integer_unit && resets.boot_mode &&
         !resets.general)
      else $error("watchdog reset reached beyond its units");

   a_wdog_refresh: assert property ( // [RULE3]
      @(posedge sys_clk) disable iff (sys_rst)
      resets.watchdog && !refresh_wr_en |=>
         $stable(refresh_interval_field))
      else $error("watchdog reset changed the refresh field");

   a_pin_starts: assert property ( // [RULE4]
      @(posedge sys_clk) disable iff (sys_rst)
      !reset_pin_n ##1 !reset_pin_n ##1 !reset_pin_n |=> resets.general)
      else $error("held reset pin did not start general reset");

   a_por_refresh: assert property ( // [RULE7]
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(resets.general) && $past(cur_reg.por_pending) |->
         refresh_interval_field == 2'h0 && !cur_reg.por_pending)
      else $error("refresh field not cleared after power-on reset");

   a_test_async: assert property ( // [RULE8]
      @(posedge sys_clk)
      !test_port_reset_n |-> test_logic_reset)
      else $error("test port reset not passed on");

   a_release_sync: assert property ( // [RULE9]
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(resets.general) |-> $past(reset_pin_n, 3))
      else $error("general reset released without synchronised pin");

   a_hold_status: assert property ( // [RULE5]
      @(posedge sys_clk) disable iff (sys_rst)
      hold_status.cpu_hold_short |-> hold_status.dram_hold_short)
      else $error("hold status flags inconsistent");

   // The hold report is loaded once, when the power-on reset ends.
   a_hold_change: assert property ( // [RULE5]
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(hold_status) |-> $fell(resets.general))
      else $error("hold status moved outside power-on release");

   a_dram_change: assert property ( // [RULE6]
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(hold_status.dram_hold_short) |-> $past(cur_reg.por_pending))
      else $error("memory hold flag moved after power-on reset");

   a_gen_scope: assert property ( // [RULE1]
      @(posedge sys_clk) disable iff (sys_rst)
      resets.general |-> resets.integer_unit && resets.boot_mode &&
         !resets.watchdog)
      else $error("general reset did not reach every unit");

   a_field_frozen: assert property ( // [RULE7]
      @(posedge sys_clk) disable iff (sys_rst)
      resets.general |=>
         $stable(refresh_interval_field) || $fell(resets.general))
      else $error("refresh field moved during general reset");

   // Outside a general reset the field belongs to software alone.
   a_field_write: assert property ( // [RULE3]
      @(posedge sys_clk) disable iff (sys_rst)
      !resets.general && refresh_wr_en |=>
         refresh_interval_field == $past(refresh_wr_data))
      else $error("refresh field write was lost");

   // The pin reaches the state three edges late: two synchroniser stages, then the state register.
   a_pin_holds: assert property ( // [RULE4]
      @(posedge sys_clk) disable iff (sys_rst)
      !$past(reset_pin_n, 2) |=> resets.general)
      else $error("low reset pin did not hold general reset");

   a_trap_ignored: assert property ( // [RULE2]
      @(posedge sys_clk) disable iff (sys_rst)
      resets.general && trap_taken |=> !resets.watchdog)
      else $error("trap during general reset started watchdog");

   a_wdog_cause: assert property ( // [RULE2]
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(resets.watchdog) |-> $past(wdog_cause))
      else $error("watchdog reset without a disabled trap");

endmodule

//--- tb/board_reset_model.sv
module board_reset_model (
   input  wire logic        sys_clk,          // Processor clock.
   input  wire logic        sys_rst,          // Power-up, high.
   input  wire logic        start,            // Ask for an external reset.
   input  wire logic [12:0] hold_len,         // Clocks to hold the pin low.
   output logic             reset_pin_n = 1'b0 // Board reset pin.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [12:0] cnt_reg = 13'h0;
   // A hold of 4000 or more keeps both power-up minimums; shorter holds
   // are offered on purpose so the processor can report them.
   always @(posedge sys_clk) begin
      if (sys_rst || start) begin
         cnt_reg <= hold_len;
         reset_pin_n <= 1'b0;
      end else if (cnt_reg != 13'h0) begin
         cnt_reg <= cnt_reg - 13'h1;
      end else begin
         reset_pin_n <= 1'b1;
      end
   end
endmodule

//--- tb/processor_reset_control_tb.sv
module processor_reset_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, reset_pin_n, board_start = 1'b0;
   logic        trap_taken = 1'b0, trap_enable_bit = 1'b1, refresh_wr_en = 1'b0;
   logic [1:0]  refresh_wr_data = 2'h0, refresh_interval_field, d;
   logic        test_port_reset_n = 1'b1, test_logic_reset, en;
   logic [12:0] hold_len = 13'hFA0;
   reset_ctl_pkg::reset_out_t   resets;
   reset_ctl_pkg::hold_status_t hold_status;
   int num_errors = 0, compares = 0, seed = 32'h3FC9, n;
   int holds[3] = '{6, 20, 4000};

   always #25 sys_clk = ~sys_clk;

   board_reset_model partner (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .start(board_start), .hold_len(hold_len), .reset_pin_n(reset_pin_n));
   processor_reset_control dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reset_pin_n(reset_pin_n), .trap_taken(trap_taken),
      .trap_enable_bit(trap_enable_bit), .refresh_wr_en(refresh_wr_en),
      .refresh_wr_data(refresh_wr_data), .test_port_reset_n(test_port_reset_n),
      .resets(resets), .refresh_interval_field(refresh_interval_field),
      .hold_status(hold_status), .test_logic_reset(test_logic_reset));

   function automatic logic [1:0] exp_hold(input int h);
      return {h < 16, h < 4000};
   endfunction
   // Watchdog lines stand for four cycles; general stays low throughout.
   function automatic logic [3:0] exp_resets(input logic e, input int k);
      return (k < 5 && !e) ? 4'h7 : 4'h0;
   endfunction

   task final_report;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task check(input logic [3:0] seen, input logic [3:0] exp, input string s);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, s, seen, exp);
      end
   endtask
   // Counts rising edges until the chosen line reaches v; bounded.
   task edges_until(input logic pin, input logic v, output int k);
      k = 0;
      while ((pin ? reset_pin_n : resets.general) !== v) begin
         @(posedge sys_clk);
         #1;
         k++;
         if (k > 5000) begin
            num_errors++;
            $display("Error at %0t: wait ran out", $time);
            final_report();
         end
      end
   endtask

   initial begin
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         sys_rst <= 1'b1;
         hold_len <= 13'(holds[i]);
         repeat (2) @(posedge sys_clk);
         sys_rst <= 1'b0;
         refresh_wr_en <= 1'b1;
         refresh_wr_data <= 2'h3;
         @(posedge sys_clk);
         refresh_wr_en <= 1'b0;
         edges_until(1'b0, 1'b0, n);
         check(4'(refresh_interval_field), 4'h0, "field");
         check(4'(hold_status), 4'(exp_hold(holds[i])), "hold");
         $display("Test power-on hold %0d done", holds[i]);
      end
      for (int i = 0; i < 24; i++) begin
         d = 2'($random(seed));
         en = (i < 2) ? 1'(i) : 1'($random(seed));
         @(posedge sys_clk);
         refresh_wr_en <= 1'b1;
         refresh_wr_data <= d;
         trap_taken <= 1'b1;
         trap_enable_bit <= en;
         @(posedge sys_clk);
         refresh_wr_en <= 1'b0;
         trap_taken <= 1'b0;
         trap_enable_bit <= 1'($random(seed));
         for (int k = 1; k <= 5; k++) begin
            @(negedge sys_clk);
            check(resets, exp_resets(en, k), "watchdog");
         end
         check(4'(refresh_interval_field), 4'(d), "field kept");
      end
      $display("Test watchdog done");
      @(posedge sys_clk);
      hold_len <= 13'h10;
      board_start <= 1'b1;
      @(posedge sys_clk);
      board_start <= 1'b0;
      edges_until(1'b0, 1'b1, n);
      check(4'(n), 4'h3, "general rise");
      trap_taken <= 1'b1;
      trap_enable_bit <= 1'b0;
      @(posedge sys_clk);
      trap_taken <= 1'b0;
      @(negedge sys_clk);
      check(resets, 4'hE, "trap in reset");
      edges_until(1'b1, 1'b1, n);
      edges_until(1'b0, 1'b0, n);
      check(4'(n), 4'h3, "general fall");
      check(4'(refresh_interval_field), 4'(d), "field after pin");
      $display("Test pin reset done");
      @(negedge sys_clk);
      #7 test_port_reset_n <= 1'b0;
      #1 check(4'(test_logic_reset), 4'h1, "test reset on");
      #5 test_port_reset_n <= 1'b1;
      #1 check(4'(test_logic_reset), 4'h0, "test reset off");
      $display("Test port reset done");
      final_report();
   end
endmodule
